// file: verilog/tsa_pkg.sv
/*
  tsa_pkg: shared constants and types of the pcm time slot assigner.
  Assumes one system clock; all pin timing is recovered by sampling.
*/
package tsa_pkg;

  // ==========================================================
  // apb register map
  localparam int             APB_AW          = 8;
  localparam logic [7:0]     CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]     STATUS_OFFSET   = 8'h04;
  localparam logic [7:0]     WORDS_OFFSET    = 8'h08;
  localparam int             CTRL_VARIANT_BIT = 0;

  // ==========================================================
  // positions of the sampled pins in the synchroniser vector
  localparam int PIN_PORT_CLK  = 0;
  localparam int PIN_GROUP_SEL = 1;
  localparam int PIN_SLOT_DI   = 2;
  localparam int PIN_STAT_DI   = 3;
  localparam int PIN_TX_FS     = 4;
  localparam int PIN_RX_FS     = 5;
  localparam int PIN_BCLK1     = 6;
  localparam int PIN_BCLK2     = 7;
  localparam int PIN_RING_CLR  = 8;
  localparam int PIN_HOOK      = 9;
  localparam int PIN_ID_LSB    = 10;
  localparam int ID_W          = 5;
  localparam int PIN_W         = 15;

  // ==========================================================
  // framing and serial word layout
  localparam int             SLOT_SHIFT      = 3;       // eight bits per slot
  localparam int             SLOT_W          = 6;
  localparam int             BIT_CNT_W       = 9;
  localparam logic [8:0]     BIT_CNT_MAX     = 9'h1ff;
  localparam logic [1:0]     ACK_DELAY_EDGES = 2'h3;
  localparam logic [2:0]     WORD_LAST_BIT   = 3'h7;
  localparam int             MODE_MSB        = 7;
  localparam int             MODE_LSB        = 6;
  localparam int             STAT_MSB        = 7;
  localparam int             STAT_LSB        = 5;

  // mode field as {first bit, second bit}
  localparam logic [1:0]     MODE_BOTH       = 2'h0;
  localparam logic [1:0]     MODE_TX_ONLY    = 2'h1;
  localparam logic [1:0]     MODE_RX_ONLY    = 2'h2;
  localparam logic [1:0]     MODE_IDLE       = 2'h3;

  // ==========================================================
  // reset values
  localparam logic           RST_VARIANT     = 1'h0;
  localparam logic [5:0]     RST_SLOT        = 6'h00;
  localparam logic           RST_OFF         = 1'h1;
  localparam logic [2:0]     RST_STATUS      = 3'h0;
  localparam logic           RST_POWER_N     = 1'h1;

  // ==========================================================
  // serial port states
  typedef enum logic [1:0] {
    PORT_READY,
    PORT_FULL,
    PORT_ACK_WAIT,
    PORT_ACK_LOW
  } tsa_port_e;

  // read-only status register layout
  typedef struct packed {
    logic [10:0] pad;
    tsa_port_e   port_state;
    logic        power_down_n;
    logic [2:0]  line_status;
    logic        ack_low;
    logic        rx_off;
    logic        tx_off;
    logic [5:0]  rx_slot;
    logic [5:0]  tx_slot;
  } tsa_status_s;

endpackage

// file: verilog/tsa_slot_assigner.sv
/*
  tsa_slot_assigner: per-channel time slot assigner for a pcm codec.
  Serial programming port, slot enable generation, acknowledge,
  status, power-down and hook multiplexing, plus an apb slave.
  Assumes all pins are asynchronous to clk_sys and slow against it
  (bit clocks up to a few MHz, port clock well below that); every
  pin passes two flip-flops before use. Open-drain pins are given
  as level and enable; the wire and its pull-up live outside.
*/
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps

// Function
// RQ1 - acknowledge low three bit clocks after sync
// RQ2 - only the matching accepting unit acknowledges
// RQ3 - acknowledge is open drain, pulled up
// RQ4 - slot rate is bit clock over eight
// RQ5 - variant selects bit clock for receive
// RQ6 - frame sync leading edge marks bit zero
// RQ7 - addressed slot zeros may differ by bits
// RQ8 - group variant framing fully independent
// RQ9 - enable high eight bits at slot number
// RQ10 - slot one covers bits eight to fifteen
// RQ11 - words arrive first bit first, fixed layout
// RQ12 - mode 00 loads both, enables both
// RQ13 - mode 10 loads receive only
// RQ14 - mode 01 loads transmit only
// RQ15 - mode 11 idles, disables enables; group variant disables transmit only, receive keeps running
// RQ16 - accepted transfer loads status outputs
// RQ17 - power down follows mode bits
// RQ18 - hook out inverted during transmit slot
// RQ19 - hook keeps working while transmit disabled
// RQ20 - host shares lines, selects group
// RQ21 - capture both words on falling port clock
// RQ22 - host holds select until acknowledge
// RQ23 - addressed variant accepts only on match
// RQ24 - ring clear forces status two low
// RQ25 - transfer crosses safely into framing logic
// RQ26 - port ready again after acknowledge frame
module tsa_slot_assigner (
  // system
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tsa_pkg::APB_AW-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  // serial programming port
  input  wire logic                        port_clock,
  input  wire logic                        group_select,
  input  wire logic                        slot_mode_serial_in,
  input  wire logic                        status_address_serial_in,
  input  wire logic [tsa_pkg::ID_W-1:0]    hardwired_unit_id,
  output logic                             ack_out,
  output logic                             ack_oe,
  // framing
  input  wire logic                        primary_bit_clock,
  input  wire logic                        secondary_bit_clock,
  input  wire logic                        transmit_frame_sync,
  input  wire logic                        receive_frame_sync,
  output logic                             transmit_slot_enable,
  output logic                             receive_slot_enable,
  // supervision
  input  wire logic                        ring_bit_clear,
  input  wire logic                        hook_state_in,
  output logic [2:0]                       line_status_outputs,
  output logic                             idle_power_down_n,
  output logic                             hook_bus_out_n,
  output logic                             hook_oe
);

  // ==========================================================
  // state of the whole block
  typedef struct packed {
    logic [tsa_pkg::PIN_W-1:0]     sync1;
    logic [tsa_pkg::PIN_W-1:0]     sync2;
    logic [tsa_pkg::PIN_W-1:0]     prev;
    logic                          variant_group;
    tsa_pkg::tsa_port_e            port_state;
    logic [2:0]                    shift_cnt;
    logic [7:0]                    slot_word;
    logic [7:0]                    stat_word;
    logic                          accepted;
    logic [1:0]                    ack_cnt;
    logic [tsa_pkg::BIT_CNT_W-1:0] tx_cnt;
    logic [tsa_pkg::BIT_CNT_W-1:0] rx_cnt;
    logic                          tx_run;
    logic                          rx_run;
    logic                          tx_fs_seen;
    logic                          rx_fs_seen;
    logic [5:0]                    tx_slot;
    logic [5:0]                    rx_slot;
    logic                          tx_valid;
    logic                          tx_off;
    logic                          rx_off;
    logic                          halted;
    logic                          tx_in_slot;
    logic [2:0]                    status;
    logic                          power_down_n;
    logic                          tx_en;
    logic                          rx_en;
    logic                          hook_oe;
    logic                          ack_oe;
    logic                          od_level;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
  } tsa_state_s;

  tsa_state_s                 st;
  tsa_state_s                 next_st;
  logic [tsa_pkg::PIN_W-1:0]  pins;
  logic                       port_fall;
  logic                       tx_rise;
  logic                       rx_rise;
  logic                       tx_start;
  logic                       rx_start;
  logic                       apb_access;
  tsa_pkg::tsa_status_s       status_word;

  // ==========================================================
  // pin gathering and edge detection on synchronised copies
  assign pins = {hardwired_unit_id, hook_state_in, ring_bit_clear,
                 secondary_bit_clock, primary_bit_clock,
                 receive_frame_sync, transmit_frame_sync,
                 status_address_serial_in, slot_mode_serial_in,
                 group_select, port_clock};

  // falling port clock takes a bit; bit clock rising edges time frames
  assign port_fall = st.prev[tsa_pkg::PIN_PORT_CLK] & ~st.sync2[tsa_pkg::PIN_PORT_CLK];
  assign tx_rise   = st.sync2[tsa_pkg::PIN_BCLK1] & ~st.prev[tsa_pkg::PIN_BCLK1];   // [RQ5]
  assign rx_rise   = st.variant_group                                               // [RQ5]
                     ? (st.sync2[tsa_pkg::PIN_BCLK2] & ~st.prev[tsa_pkg::PIN_BCLK2])
                     : tx_rise;

  // sync high at a bit clock edge where it was low at the previous one
  assign tx_start = tx_rise & st.sync2[tsa_pkg::PIN_TX_FS] & ~st.tx_fs_seen;        // [RQ6]
  assign rx_start = rx_rise & st.sync2[tsa_pkg::PIN_RX_FS] & ~st.rx_fs_seen;        // [RQ6]

  // zero-wait-free apb: answer one cycle into the access phase
  assign apb_access = psel & penable & ~st.pready;

  // status register view
  always_comb begin
    status_word              = '0;
    status_word.port_state   = st.port_state;
    status_word.power_down_n = st.power_down_n;
    status_word.line_status  = st.status;
    status_word.ack_low      = st.ack_oe;
    status_word.rx_off       = st.rx_off;
    status_word.tx_off       = st.tx_off;
    status_word.rx_slot      = st.rx_slot;
    status_word.tx_slot      = st.tx_slot;
  end

  // ==========================================================
  // next state of the whole block
  always_comb begin
    logic [1:0] mode;
    logic [7:0] new_slot_word;
    logic [7:0] new_stat_word;
    mode          = st.slot_word[tsa_pkg::MODE_MSB:tsa_pkg::MODE_LSB];
    new_slot_word = {st.slot_word[6:0], st.sync2[tsa_pkg::PIN_SLOT_DI]};
    new_stat_word = {st.stat_word[6:0], st.sync2[tsa_pkg::PIN_STAT_DI]};
    next_st       = st;

    // two-stage synchronisers and a delayed copy for edges
    next_st.sync1 = pins;                                                           // [RQ25]
    next_st.sync2 = st.sync1;                                                       // [RQ25]
    next_st.prev  = st.sync2;

    // serial port: shift both words while selected
    if (st.port_state == tsa_pkg::PORT_READY) begin
      if (!st.sync2[tsa_pkg::PIN_GROUP_SEL]) begin
        next_st.shift_cnt = 3'h0;                      // select low restarts a word
      end else if (port_fall) begin
        next_st.slot_word = new_slot_word;                                          // [RQ21] [RQ11]
        next_st.stat_word = new_stat_word;                                          // [RQ21] [RQ11]
        if (st.shift_cnt == tsa_pkg::WORD_LAST_BIT) begin
          next_st.shift_cnt  = 3'h0;
          next_st.port_state = tsa_pkg::PORT_FULL;                                  // [RQ25]
          next_st.accepted   = st.variant_group ||                                  // [RQ23]
                               (new_stat_word[tsa_pkg::ID_W-1:0] ==
                                st.sync2[tsa_pkg::PIN_ID_LSB +: tsa_pkg::ID_W]);
        end else begin
          next_st.shift_cnt = st.shift_cnt + 3'h1;
        end
      end
    end

    // word takes effect at the next transmit frame start
    if (tx_start && st.port_state == tsa_pkg::PORT_FULL) begin
      if (st.accepted) begin
        case (mode)
          tsa_pkg::MODE_BOTH: begin
            next_st.tx_slot  = st.slot_word[tsa_pkg::SLOT_W-1:0];                   // [RQ12]
            next_st.rx_slot  = st.slot_word[tsa_pkg::SLOT_W-1:0];                   // [RQ12]
            next_st.tx_valid = 1'b1;
            next_st.tx_off   = 1'b0;                                                // [RQ12]
            next_st.rx_off   = 1'b0;
            next_st.halted   = 1'b0;
          end
          tsa_pkg::MODE_TX_ONLY: begin
            next_st.tx_slot  = st.slot_word[tsa_pkg::SLOT_W-1:0];                   // [RQ14]
            next_st.tx_valid = 1'b1;
            next_st.tx_off   = 1'b0;
            next_st.rx_off   = 1'b0;
            next_st.halted   = 1'b0;
          end
          tsa_pkg::MODE_RX_ONLY: begin
            next_st.rx_slot = st.slot_word[tsa_pkg::SLOT_W-1:0];                    // [RQ13]
            next_st.rx_off  = 1'b0;
            next_st.halted  = 1'b0;
          end
          tsa_pkg::MODE_IDLE: begin
            next_st.tx_off = 1'b1;                                                  // [RQ15]
            if (!st.variant_group) begin
              next_st.rx_off = 1'b1;                                                // [RQ15]
              next_st.halted = 1'b1;                                                // [RQ15]
            end
          end
          default: begin
            next_st.halted = st.halted;
          end
        endcase
        if (!st.variant_group) begin
          next_st.status = st.stat_word[tsa_pkg::STAT_MSB:tsa_pkg::STAT_LSB];       // [RQ16]
        end else begin
          next_st.power_down_n = (mode != tsa_pkg::MODE_IDLE);                      // [RQ17]
        end
        next_st.ack_cnt    = 2'h0;
        next_st.port_state = tsa_pkg::PORT_ACK_WAIT;                                // [RQ2]
      end else begin
        next_st.port_state = tsa_pkg::PORT_READY;                                   // [RQ16]
      end
    end else if (tx_start && st.port_state == tsa_pkg::PORT_ACK_LOW) begin
      next_st.ack_oe     = 1'b0;                                                    // [RQ1]
      next_st.port_state = tsa_pkg::PORT_READY;                                     // [RQ26]
    end else if (tx_rise && st.port_state == tsa_pkg::PORT_ACK_WAIT) begin
      if (st.ack_cnt == tsa_pkg::ACK_DELAY_EDGES - 2'h1) begin
        next_st.ack_oe     = 1'b1;                                                  // [RQ1] [RQ3]
        next_st.port_state = tsa_pkg::PORT_ACK_LOW;
      end else begin
        next_st.ack_cnt = st.ack_cnt + 2'h1;
      end
    end

    // transmit framing on the primary bit clock
    if (tx_rise) begin
      next_st.tx_fs_seen = st.sync2[tsa_pkg::PIN_TX_FS];
      if (tx_start) begin
        next_st.tx_cnt = '0;                                                        // [RQ6]
        next_st.tx_run = 1'b1;
      end else if (st.tx_run) begin
        if (st.tx_cnt == tsa_pkg::BIT_CNT_MAX) begin
          next_st.tx_run = 1'b0;
        end else begin
          next_st.tx_cnt = st.tx_cnt + 9'h001;                                      // [RQ4]
        end
      end
      if (next_st.halted) begin
        next_st.tx_run = 1'b0;                                                      // [RQ15]
      end
      next_st.tx_in_slot = next_st.tx_run &&                                        // [RQ9] [RQ10]
                           (next_st.tx_cnt[tsa_pkg::BIT_CNT_W-1:tsa_pkg::SLOT_SHIFT]
                            == next_st.tx_slot);
      next_st.tx_en = next_st.tx_in_slot && !next_st.tx_off;                        // [RQ9]
    end

    // receive framing on the variant-selected bit clock and its own sync
    if (rx_rise) begin
      next_st.rx_fs_seen = st.sync2[tsa_pkg::PIN_RX_FS];                            // [RQ7] [RQ8]
      if (rx_start) begin
        next_st.rx_cnt = '0;                                                        // [RQ6]
        next_st.rx_run = 1'b1;
      end else if (st.rx_run) begin
        if (st.rx_cnt == tsa_pkg::BIT_CNT_MAX) begin
          next_st.rx_run = 1'b0;
        end else begin
          next_st.rx_cnt = st.rx_cnt + 9'h001;                                      // [RQ4]
        end
      end
      if (next_st.halted) begin
        next_st.rx_run = 1'b0;                                                      // [RQ15]
      end
      next_st.rx_en = next_st.rx_run && !next_st.rx_off &&                          // [RQ9] [RQ10]
                      (next_st.rx_cnt[tsa_pkg::BIT_CNT_W-1:tsa_pkg::SLOT_SHIFT]
                       == next_st.rx_slot);
    end

    // halting also drops enables between edges
    if (next_st.halted) begin
      next_st.tx_en = 1'b0;
      next_st.rx_en = 1'b0;
    end

    // hook bus, group variant only: pull low while in the transmit slot and hook is high
    next_st.hook_oe = next_st.tx_in_slot && next_st.tx_valid &&                     // [RQ18] [RQ19]
                      st.variant_group && st.sync2[tsa_pkg::PIN_HOOK];

    // ring clear wins over any load of status bit two
    if (st.sync2[tsa_pkg::PIN_RING_CLR]) begin
      next_st.status[2] = 1'b0;                                                     // [RQ24]
    end

    // open-drain pins only ever drive low
    next_st.od_level = 1'b0;                                                        // [RQ3]

    // apb slave: answer, decode, write control, read views
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.prdata  = 32'h0000_0000;
    if (apb_access) begin
      next_st.pready = 1'b1;
      case (paddr)
        tsa_pkg::CTRL_OFFSET: begin
          if (pwrite && pstrb[0]) begin
            next_st.variant_group = pwdata[tsa_pkg::CTRL_VARIANT_BIT];
          end
          if (!pwrite) begin
            next_st.prdata[tsa_pkg::CTRL_VARIANT_BIT] = st.variant_group;
          end
        end
        tsa_pkg::STATUS_OFFSET: begin
          if (!pwrite) begin
            next_st.prdata = status_word;
          end
        end
        tsa_pkg::WORDS_OFFSET: begin
          if (!pwrite) begin
            next_st.prdata = {16'h0000, st.stat_word, st.slot_word};
          end
        end
        default: begin
          next_st.pslverr = 1'b1;                    // unmapped address
        end
      endcase
    end
  end

  // ==========================================================
  // state register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st               <= '0;
      st.port_state    <= tsa_pkg::PORT_READY;
      st.variant_group <= tsa_pkg::RST_VARIANT;
      st.tx_slot       <= tsa_pkg::RST_SLOT;
      st.rx_slot       <= tsa_pkg::RST_SLOT;
      st.tx_off        <= tsa_pkg::RST_OFF;
      st.rx_off        <= tsa_pkg::RST_OFF;
      st.status        <= tsa_pkg::RST_STATUS;
      st.power_down_n  <= tsa_pkg::RST_POWER_N;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign pready               = st.pready;
  assign prdata               = st.prdata;
  assign pslverr              = st.pslverr;
  assign ack_out              = st.od_level;
  assign ack_oe               = st.ack_oe;
  assign transmit_slot_enable = st.tx_en;
  assign receive_slot_enable  = st.rx_en;
  assign line_status_outputs  = st.status;
  assign idle_power_down_n    = st.power_down_n;
  assign hook_bus_out_n       = st.od_level;
  assign hook_oe              = st.hook_oe;

endmodule

// file: dv/tsa_chk.sv
/*
  tsa_chk: pin checks for the slot assigner.
  assumes bit clocks far slower than clk_sys.
*/
`timescale 1ns/100ps
module tsa_chk (
  // system and apb
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // framing and supervision
  input wire logic       primary_bit_clock,
  input wire logic       transmit_frame_sync,
  input wire logic       transmit_slot_enable,
  input wire logic       ring_bit_clear,
  input wire logic       ack_out,
  input wire logic       ack_oe,
  input wire logic       hook_bus_out_n,
  input wire logic       hook_oe,
  input wire logic [2:0] line_status_outputs,
  input wire logic       idle_power_down_n
);
  // ==========
  // bit index in frame, bits seen in tx window
  logic       bclk_q;
  logic       fs_q;
  logic [7:0] fbit;
  logic [3:0] tbits;
  wire        rise = primary_bit_clock & ~bclk_q;
  always_ff @(posedge clk_sys) begin
    bclk_q <= primary_bit_clock;
    if (!rst_n) begin
      fs_q <= 1'b0;
      fbit <= 8'h00;
      tbits <= 4'h0;
    end else begin
      if (rise) begin
        fs_q <= transmit_frame_sync;
        fbit <= (transmit_frame_sync & ~fs_q) ? 8'h00 : fbit + {7'h00, fbit != 8'hff};
      end
      tbits <= !transmit_slot_enable ? 4'h0 : tbits + {3'h0, rise};
    end
  end
  // ==========
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer late");
  ack_level_a: assert property (ack_oe |-> !ack_out) else $error("ack high");
  ack_delay_a: assert property ($rose(ack_oe) |-> fbit == 8'h03)
    else $error("ack not on third bit");
  ack_release_a: assert property ($fell(ack_oe) |-> fbit == 8'h00)
    else $error("ack release off frame");
  slot_width_a: assert property ($fell(transmit_slot_enable) |-> tbits == 4'h8)
    else $error("tx slot width");
  ring_clear_a: assert property (ring_bit_clear [*6] |-> !line_status_outputs[2])
    else $error("ring bit kept");
  status_frame_a: assert property ($changed(line_status_outputs[1:0]) |-> fbit == 8'h00)
    else $error("status off frame");
  power_frame_a: assert property ($changed(idle_power_down_n) |-> fbit == 8'h00)
    else $error("power down off frame");
  hook_level_a: assert property (hook_oe |-> !hook_bus_out_n) else $error("hook high");
  ack_c: cover property ($rose(ack_oe));
  idle_c: cover property ($fell(idle_power_down_n));
  hook_c: cover property ($rose(hook_oe));
endmodule

bind tsa_slot_assigner tsa_chk u_chk (.clk_sys, .rst_n, .psel, .penable, .pready,
  .primary_bit_clock, .transmit_frame_sync, .transmit_slot_enable, .ring_bit_clear,
  .ack_out, .ack_oe, .hook_bus_out_n, .hook_oe, .line_status_outputs, .idle_power_down_n);

// file: dv/tsa_host.sv
/*
  tsa_host: host processor and codec clock model.
  assumes ack_wire is the resolved open-drain wire.
*/
`timescale 1ns/100ps
module tsa_host (
  // serial port
  output logic      port_clock,
  output logic      group_select,
  output logic      slot_mode_serial_in,
  output logic      status_address_serial_in,
  input  wire logic ack_wire,
  // framing
  output logic      primary_bit_clock,
  output logic      secondary_bit_clock,
  output logic      transmit_frame_sync,
  output logic      receive_frame_sync,
  output int        bit_idx
);
  // ==========
  // 32 bit frame, rx sync two bits after tx sync
  initial begin
    {port_clock, group_select, slot_mode_serial_in, status_address_serial_in} = 4'h0;
    {primary_bit_clock, secondary_bit_clock} = 2'h0;
    forever for (int b = 0; b < 32; b++) begin
      transmit_frame_sync = (b == 0);
      receive_frame_sync = (b == 2);
      #32;
      primary_bit_clock = 1'b1;
      bit_idx = b;
      #32;
      primary_bit_clock = 1'b0;
    end
  end
  // second bit clock at an unrelated rate
  always #40 secondary_bit_clock = ~secondary_bit_clock;
  // one transfer, bits shown while clock high
  task automatic send(input logic [7:0] sw, input logic [7:0] aw, input bit acked);
    group_select = 1'b1;
    #200;
    for (int i = 7; i >= 0; i--) begin
      slot_mode_serial_in = sw[i];
      status_address_serial_in = aw[i];
      #100;
      port_clock = 1'b1;
      #200;
      port_clock = 1'b0;
      #100;
    end
    slot_mode_serial_in = ~sw[0];
    status_address_serial_in = ~aw[0];
    if (acked) begin
      wait (ack_wire === 1'b0);
      wait (ack_wire === 1'b1);
    end else begin
      #6000;
    end
    group_select = 1'b0;
  endtask
endmodule

// file: dv/testbench.sv
/*
  testbench: self checking bench for the slot assigner.
  assumes tsa_host for pins; checker is bound.
*/
`timescale 1ns/100ps
module testbench;
  // ==========
  // signals
  logic        clk_sys, rst_n, psel, penable, pwrite, ring_bit_clear, hook_state_in;
  logic        pready, pslverr, ack_out, ack_oe, err, idle_power_down_n, hook_oe;
  logic        port_clock, group_select, slot_mode_serial_in, status_address_serial_in;
  logic        primary_bit_clock, secondary_bit_clock, transmit_frame_sync;
  logic        receive_frame_sync, transmit_slot_enable, receive_slot_enable;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  q;
  int          bit_idx, miscompares, checked, cyc, f[3], c[3];
  wire         ack_wire = ack_oe ? ack_out : 1'b1;
  tsa_slot_assigner DUT (.*, .pstrb(4'hf), .hardwired_unit_id(5'h10),
    .line_status_outputs(q), .hook_bus_out_n());
  tsa_host host (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // cycle limit cuts a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      summarize();
    end
  end
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // first bit and width of tx, rx, hook in one frame; -2 skips
  task automatic frame(input string nm, input int et, input int er, input int eh);
    int          e[3];
    logic [2:0]  s;
    e = '{et, er, eh};
    f = '{-1, -1, -1};
    c = '{0, 0, 0};
    @(negedge primary_bit_clock iff bit_idx == 31);
    repeat (32) begin
      @(negedge primary_bit_clock);
      s = {transmit_slot_enable, receive_slot_enable, hook_oe};
      for (int k = 0; k < 3; k++) if (s[2-k] === 1'b1) begin
        c[k]++;
        f[k] = (f[k] < 0) ? bit_idx : f[k];
      end
    end
    for (int k = 0; k < 3; k++) if (e[k] > -2) begin
      chk(f[k], e[k]);
      chk(c[k], (e[k] < 0) ? 0 : 8);
    end
    $display("test %s done", nm);
  endtask
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite, ring_bit_clear, hook_state_in} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, tsa_pkg::STATUS_OFFSET, 32'h0000_0000);
    chk(rd, 32'h0004_3000);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    host.send(8'h01, 8'h70, 1'b1);
    frame("both", 8, 10, -1);
    chk(32'(q), 32'h0000_0003);
    apb(1'b0, tsa_pkg::STATUS_OFFSET, 32'h0000_0000);
    chk(32'(rd[20:19]), 32'h0000_0000);
    host.send(8'hc0, 8'h81, 1'b0);
    frame("mismatch", 8, 10, -1);
    chk(32'(q), 32'h0000_0003);
    host.send(8'h82, 8'hf0, 1'b1);
    frame("rx only", 8, 18, -1);
    chk(32'(q), 32'h0000_0007);
    @(posedge clk_sys) ring_bit_clear <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(32'(q), 32'h0000_0003);
    ring_bit_clear <= 1'b0;
    host.send(8'h43, 8'h10, 1'b1);
    frame("tx only", 24, 18, -1);
    host.send(8'hc0, 8'h10, 1'b1);
    frame("idle", -1, -1, -1);
    apb(1'b1, tsa_pkg::CTRL_OFFSET, 32'h0000_0001);
    hook_state_in <= 1'b1;
    host.send(8'h01, 8'h00, 1'b1);
    frame("group", 8, -2, 8);
    chk(32'(idle_power_down_n), 32'h0000_0001);
    host.send(8'hc0, 8'h00, 1'b1);
    frame("power down", -1, -2, 8);
    chk(32'(idle_power_down_n), 32'h0000_0000);
    @(posedge clk_sys) hook_state_in <= 1'b0;
    frame("hook low", -1, -2, -1);
    host.send(8'h82, 8'h00, 1'b1);
    chk(32'(idle_power_down_n), 32'h0000_0001);
    summarize();
  end
endmodule
